//--- tws_params.svh
// constants for the three-wire serial memory shifter
`ifndef TWS_PARAMS_SVH
`define TWS_PARAMS_SVH
`define TWS_CORE_HZ 25000000
`define TWS_SCK_HZ 500000
`define TWS_HALF_CYCLES (`TWS_CORE_HZ / (2 * `TWS_SCK_HZ))
`define TWS_PIN_SEL_3WIRE 2'h3
`define TWS_MAX_BITS 4'h8
`define TWS_BIT_WFR 7
`define TWS_BIT_BUSY 6
`define TWS_BIT_HIZ 5
`define TWS_BIT_RD 4
`define TWS_CNT_MSB 3
`define TWS_DATA_RESET 8'h00
`endif

//--- tws_pkg.sv
// types for the three-wire serial memory shifter
package tws_pkg;
  typedef enum logic [1:0] {
    TWS_IDLE = 2'b00,
    TWS_LOW = 2'b01,
    TWS_HIGH = 2'b11,
    TWS_WAIT = 2'b10
  } tws_state_t;
  typedef struct packed {
    logic waitReady;
    logic releaseLine;
    logic readDir;
    logic [3:0] shiftLength;
  } tws_cmd_t;
endpackage : tws_pkg

//--- tws_shifter.sv
// three-wire serial memory shifter driven by a control and a data register
`timescale 1ns/10ps
`include "tws_params.svh"

module tws_shifter #(
  // core cycles per half period of the serial clock; keep it at 3 or more
  // so a read bit has crossed the synchroniser before it is sampled
  parameter logic [4:0] HALF_CYCLES = 5'(`TWS_HALF_CYCLES)
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [1:0] memoryPinSelect,
  input wire logic ctrlWrite,
  input wire logic dataWrite,
  input wire logic [7:0] writeData,
  output logic [7:0] ctrlReadData,
  output logic [7:0] dataReadData,
  output logic transferDoneInterrupt,
  output logic serialClk,
  input wire logic serialDataIn,
  output logic serialDataOut,
  output logic serialDataOe
);
  import tws_pkg::*;

  //////////////////////////////////////////////////////////////////////
  // sequencer state and latched command
  tws_state_t state;
  tws_state_t next_state;
  tws_cmd_t cmd;
  tws_cmd_t next_cmd;

  // serial clock timing and bit count
  logic [4:0] halfCnt;
  logic [4:0] next_halfCnt;
  logic [3:0] bitsLeft;
  logic [3:0] next_bitsLeft;
  logic halfEnd;
  logic lastRise;

  // shifter, busy and pin drive
  logic [7:0] shiftReg;
  logic [7:0] next_shiftReg;
  logic busy;
  logic next_busy;
  logic next_serialClk;
  logic next_serialDataOut;
  logic next_serialDataOe;

  // register read views and done pulse
  logic next_done;
  logic [7:0] next_ctrlReadData;
  logic [7:0] next_dataReadData;

  // data line synchroniser and decodes
  logic sdiMeta;
  logic sdiSync;
  logic sdiPrev;
  logic sdiRise;
  logic [3:0] clampLen;
  logic cmdAccept;

  //////////////////////////////////////////////////////////////////////
  // data line synchroniser and rising edge detect
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      // low matches the line driven low in reset, so no false ready edge
      sdiMeta <= 1'b0;
      sdiSync <= 1'b0;
      sdiPrev <= 1'b0;
    end
    else
    begin
      sdiMeta <= serialDataIn;
      sdiSync <= sdiMeta;
      sdiPrev <= sdiSync;
    end
  end

  // ready edge seen on the data line; only the wait state reads it,
  // so edges made while shifting are harmless
  assign sdiRise = sdiSync & ~sdiPrev;

  // requested length limited to eight bits
  assign clampLen = (writeData[`TWS_CNT_MSB:0] > `TWS_MAX_BITS) ?
                    `TWS_MAX_BITS : writeData[`TWS_CNT_MSB:0];

  // end of one half period of the serial clock
  assign halfEnd = (halfCnt == HALF_CYCLES - 5'd1);

  // a control write is taken only between commands in three-wire mode
  assign cmdAccept = ctrlWrite && (state == TWS_IDLE) &&
                     (memoryPinSelect == `TWS_PIN_SEL_3WIRE);

  // the rising edge about to be made is the last of the command
  assign lastRise = halfEnd && (bitsLeft == 4'd1);

  //////////////////////////////////////////////////////////////////////
  // command sequencer, next values
  always_comb
  begin
    next_state = state;
    next_cmd = cmd;
    next_halfCnt = halfCnt;
    next_bitsLeft = bitsLeft;
    next_shiftReg = shiftReg;
    next_busy = busy;
    next_serialClk = serialClk;
    next_serialDataOut = serialDataOut;
    next_serialDataOe = serialDataOe;
    next_done = 1'b0;
    case (state)
      TWS_IDLE:
      begin
        // data register written by the processor between commands
        // writes during a command are dropped, the shifter owns it then
        if (dataWrite)
        begin
          next_shiftReg = writeData;
        end
        // a control write launches a command in three-wire mode
        if (cmdAccept)
        begin
          next_cmd.readDir = writeData[`TWS_BIT_RD];
          next_cmd.releaseLine = writeData[`TWS_BIT_HIZ];
          // wait-ready only counts with release set
          next_cmd.waitReady = writeData[`TWS_BIT_WFR] &
                               writeData[`TWS_BIT_HIZ];
          next_cmd.shiftLength = clampLen;
          next_bitsLeft = clampLen;
          next_halfCnt = 5'd0;
          next_busy = 1'b1;
          next_serialClk = 1'b0;
          if (clampLen == 4'd0)
          begin
            // no clocks, data line just obeys release
            next_serialDataOe = ~writeData[`TWS_BIT_HIZ];
            next_serialDataOut = 1'b0;
            next_state = TWS_HIGH;
          end
          else
          begin
            // reads leave the line to the memory, writes present the msb
            next_serialDataOe = ~writeData[`TWS_BIT_RD];
            next_serialDataOut = next_shiftReg[7];
            next_state = TWS_LOW;
          end
        end
      end
      TWS_LOW:
      begin
        // clock low half, then rising edge
        next_halfCnt = halfCnt + 5'd1;
        if (halfEnd)
        begin
          next_halfCnt = 5'd0;
          next_serialClk = 1'b1;
          next_bitsLeft = bitsLeft - 4'd1;
          if (cmd.readDir)
          begin
            // sample at the rising edge, shift in from the bottom
            // the synchronised bit is a few cycles old, well inside the low half
            next_shiftReg = {shiftReg[6:0], sdiSync};
          end
          else
          begin
            // bit just sent leaves through the top
            next_shiftReg = {shiftReg[6:0], 1'b0};
          end
          if (lastRise && cmd.releaseLine)
          begin
            // last rising edge: let go of the data line at once
            next_serialDataOe = 1'b0;
          end
          next_state = TWS_HIGH;
        end
      end
      TWS_HIGH:
      begin
        // clock high half, then falling edge or finish
        next_halfCnt = halfCnt + 5'd1;
        // a zero-length command without wait-ready ends one cycle after it starts, with no clock
        if (halfEnd || cmd.shiftLength == 4'd0)
        begin
          next_halfCnt = 5'd0;
          next_serialClk = 1'b0;
          if (bitsLeft != 4'd0)
          begin
            // next write bit changes while the clock is low
            next_serialDataOut = shiftReg[7];
            next_state = TWS_LOW;
          end
          else if (cmd.waitReady)
          begin
            next_state = TWS_WAIT;
          end
          else
          begin
            next_busy = 1'b0;
            next_done = 1'b1;
            next_state = TWS_IDLE;
          end
        end
      end
      TWS_WAIT:
      begin
        // memory signals ready by raising the released data line
        // a line already high on entry does not count, only a new rise does
        if (sdiRise)
        begin
          next_busy = 1'b0;
          next_done = 1'b1;
          next_state = TWS_IDLE;
        end
      end
      default:
      begin
        next_state = TWS_IDLE;
        next_busy = 1'b0;
        next_serialClk = 1'b0;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////
  // register read views, next values
  always_comb
  begin
    // busy in bit 6, write-only bits read zero
    next_ctrlReadData = 8'h00;
    next_ctrlReadData[`TWS_BIT_BUSY] = next_busy;
    // data register shows the shifter, read bits right-aligned
    next_dataReadData = next_shiftReg;
  end

  //////////////////////////////////////////////////////////////////////
  // register read views and done pulse, registers
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      transferDoneInterrupt <= 1'b0;
      ctrlReadData <= 8'h00;
      dataReadData <= `TWS_DATA_RESET;
    end
    else
    begin
      transferDoneInterrupt <= next_done;
      ctrlReadData <= next_ctrlReadData;
      dataReadData <= next_dataReadData;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // command sequencer, registers
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state <= TWS_IDLE;
      cmd <= '0;
      halfCnt <= 5'd0;
      bitsLeft <= 4'd0;
      shiftReg <= `TWS_DATA_RESET;
      busy <= 1'b0;
      serialClk <= 1'b0;
      serialDataOut <= 1'b0;
      // line driven low in reset so the memory never sees it floating
      serialDataOe <= 1'b1;
    end
    else
    begin
      state <= next_state;
      cmd <= next_cmd;
      halfCnt <= next_halfCnt;
      bitsLeft <= next_bitsLeft;
      shiftReg <= next_shiftReg;
      busy <= next_busy;
      serialClk <= next_serialClk;
      serialDataOut <= next_serialDataOut;
      serialDataOe <= next_serialDataOe;
    end
  end

endmodule : tws_shifter

//--- tws_shifter_chk.sv
// assertions on the shifter ports
`timescale 1ns/10ps
module tws_shifter_chk #(
  parameter logic [4:0] HALF_CYCLES = 5'h4
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [1:0] memoryPinSelect,
  input wire logic ctrlWrite,
  input wire logic [7:0] writeData,
  input wire logic [7:0] ctrlReadData,
  input wire logic transferDoneInterrupt,
  input wire logic serialClk,
  input wire logic serialDataOe
);
  logic busy;
  logic lastClk;
  logic [4:0] halfCnt;
  assign busy = ctrlReadData[6];
  // cycles since the serial clock last moved
  always_ff @(posedge core_clk or negedge rst_b)
    if (!rst_b)
    begin
      lastClk <= 1'b0;
      halfCnt <= 5'h0;
    end
    else
    begin
      lastClk <= serialClk;
      halfCnt <= (!busy || serialClk != lastClk) ? 5'h0 : halfCnt + 5'h1;
    end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // an accepted command write
  sequence sStart;
    ctrlWrite && memoryPinSelect == 2'h3 && !busy;
  endsequence
  a_busy_start: assert property (sStart |=> busy)
    else $error("busy did not rise");
  a_pin_refuse: assert property (ctrlWrite && memoryPinSelect != 2'h3 && !busy |=> !busy)
    else $error("command taken in other pin mode");
  a_done_pulse: assert property (transferDoneInterrupt == $fell(busy))
    else $error("done pulse not tied to busy fall");
  a_clk_idle: assert property (!busy |-> !serialClk)
    else $error("serial clock high while idle");
  a_half_period: assert property (busy && lastClk && !serialClk |-> halfCnt == HALF_CYCLES - 5'h1)
    else $error("wrong high half length");
  a_zero_len: assert property ((sStart and (writeData[3:0] == 4'h0 && !writeData[7]))
    |=> busy && serialDataOe == !$past(writeData[5]) ##1 !busy)
    else $error("zero length command wrong");
  a_read_float: assert property ((sStart and (writeData[4] && writeData[3:0] != 4'h0))
    |=> !serialDataOe)
    else $error("data line driven in read");
  a_release_edge: assert property ($fell(serialDataOe) && $past(busy) |-> $rose(serialClk))
    else $error("release not at clock rise");
endmodule : tws_shifter_chk
bind tws_shifter tws_shifter_chk #(.HALF_CYCLES(HALF_CYCLES)) u_tws_shifter_chk (
  .core_clk(core_clk), .rst_b(rst_b), .memoryPinSelect(memoryPinSelect),
  .ctrlWrite(ctrlWrite), .writeData(writeData), .ctrlReadData(ctrlReadData),
  .transferDoneInterrupt(transferDoneInterrupt), .serialClk(serialClk),
  .serialDataOe(serialDataOe));

//--- tws_mem_model.sv
// serial memory model for the shifter bench
`timescale 1ns/10ps
module tws_mem_model (
  input wire logic chipSel,
  input wire logic serialClk,
  input wire logic serialDataOut,
  input wire logic serialDataOe,
  input wire logic memLoad,
  input wire logic [7:0] memLoadVal,
  output logic serialDataIn,
  output logic [7:0] memRx
);
  logic [7:0] memTx = 8'hff;
  // line level; floats to inverse when unselected
  assign serialDataIn = serialDataOe ? serialDataOut : chipSel ? memTx[7] : !serialDataOut;
  // next read bit leaves on the clock fall
  always @(posedge memLoad or negedge serialClk)
    memTx <= memLoad ? memLoadVal : {memTx[6:0], 1'b1};
  // written bits taken on the clock rise
  always @(posedge serialClk)
    if (chipSel && serialDataOe)
      memRx <= {memRx[6:0], serialDataOut};
endmodule : tws_mem_model

//--- tws_shifter_bench.sv
// bench for the three-wire shifter
`timescale 1ns/10ps
module tws_shifter_bench;
  logic core_clk = 1'b0, rst_b, ctrlWrite, dataWrite, chipSel, memLoad;
  logic [1:0] memoryPinSelect;
  logic [7:0] writeData, memLoadVal, ctrlReadData, dataReadData, memRx, n;
  logic transferDoneInterrupt, serialClk, serialDataIn, serialDataOut, serialDataOe;
  int num_errors = 0;
  int checks_done = 0;
  tws_shifter #(.HALF_CYCLES(5'h4)) u_tws_shifter (.core_clk(core_clk), .rst_b(rst_b),
    .memoryPinSelect(memoryPinSelect), .ctrlWrite(ctrlWrite), .dataWrite(dataWrite),
    .writeData(writeData), .ctrlReadData(ctrlReadData), .dataReadData(dataReadData),
    .transferDoneInterrupt(transferDoneInterrupt), .serialClk(serialClk),
    .serialDataIn(serialDataIn), .serialDataOut(serialDataOut), .serialDataOe(serialDataOe));
  tws_mem_model u_tws_mem_model (.chipSel(chipSel), .serialClk(serialClk),
    .serialDataOut(serialDataOut), .serialDataOe(serialDataOe), .memLoad(memLoad),
    .memLoadVal(memLoadVal), .serialDataIn(serialDataIn), .memRx(memRx));
  always #20 core_clk = !core_clk;
  task chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task close_out;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : close_out
  // register strobes, one cycle each
  task wr(input logic isCtrl, input logic [7:0] d);
    @(negedge core_clk);
    ctrlWrite = isCtrl;
    dataWrite = !isCtrl;
    writeData = d;
    @(negedge core_clk);
    ctrlWrite = 1'b0;
    dataWrite = 1'b0;
  endtask : wr
  // command, then count busy cycles
  task cw(input logic [7:0] c);
    wr(1'b1, c);
    n = 8'h0;
    while (ctrlReadData[6] === 1'b1 && n < 8'hc8)
    begin
      n++;
      @(negedge core_clk);
    end
    if (n != 8'h0)
      chk({7'h0, transferDoneInterrupt}, 8'h1);
  endtask : cw
  task ld(input logic [7:0] v);
    memLoadVal = v;
    memLoad = 1'b1;
    @(negedge core_clk);
    memLoad = 1'b0;
  endtask : ld
  // watchdog
  initial
  begin
    #200000;
    num_errors++;
    close_out;
  end
  // tests
  initial
  begin
    {rst_b, ctrlWrite, dataWrite, chipSel, memLoad} = 5'h00;
    {memoryPinSelect, writeData, memLoadVal} = {2'h3, 16'h0000};
    repeat (3) @(negedge core_clk);
    rst_b = 1'b1;
    chk(ctrlReadData, 8'h00);
    chk(dataReadData, 8'h00);
    chipSel = 1'b1;
    wr(1'b0, 8'ha5);
    cw(8'h08);
    chk(n, 8'h40);
    chk(memRx, 8'ha5);
    wr(1'b0, 8'h3c);
    cw(8'h0f);
    chk(n, 8'h40);
    chk(memRx, 8'h3c);
    wr(1'b0, 8'hc0);
    cw(8'h03);
    chk(memRx & 8'h07, 8'h06);
    $display("write test done");
    ld(8'h96);
    cw(8'h18);
    chk(dataReadData, 8'h96);
    ld(8'ha0);
    cw(8'h13);
    chk(n, 8'h18);
    chk(dataReadData, 8'hb5);
    chipSel = 1'b0;
    cw(8'h00);
    chk(n, 8'h01);
    chk({7'h0, serialDataOe}, 8'h1);
    memoryPinSelect = 2'h2;
    cw(8'h08);
    chk(n, 8'h00);
    memoryPinSelect = 2'h3;
    $display("read test done");
    chipSel = 1'b1;
    cw(8'h20);
    chk(n, 8'h01);
    chk({7'h0, serialDataOe}, 8'h0);
    ld(8'h00);
    fork
      cw(8'ha1);
      begin
        repeat (20) @(negedge core_clk);
        ld(8'hff);
      end
    join
    chk({7'h0, serialDataOe}, 8'h0);
    chk({7'h0, n > 8'h10 && n < 8'h20}, 8'h01);
    cw(8'h81);
    chk(n, 8'h08);
    $display("wait test done");
    close_out;
  end
endmodule : tws_shifter_bench
